// ### include/tcp_pkg.sv
// Purpose: shared constants of the 16-bit timer with capture and its host
// Assumes: byte-wide register port on the timer, AHB-Lite on the host
// Notes:   offsets are byte locations on the timer port
package tcp_pkg;
    // timer register locations (4-bit byte address)
    localparam logic [3:0] A_CTRL_A   = 4'h0;
    localparam logic [3:0] A_CTRL_B   = 4'h1;
    localparam logic [3:0] A_CNT_LO   = 4'h2;
    localparam logic [3:0] A_CNT_HI   = 4'h3;
    localparam logic [3:0] A_CAP_LO   = 4'h4;
    localparam logic [3:0] A_CAP_HI   = 4'h5;
    localparam logic [3:0] A_CMPA_LO  = 4'h6;
    localparam logic [3:0] A_CMPA_HI  = 4'h7;
    localparam logic [3:0] A_FLAGS    = 4'h8;
    localparam logic [3:0] A_MASK     = 4'h9;
    // control field positions
    localparam int A_WGM_LO = 0;
    localparam int B_CS_LO  = 0;
    localparam int B_WGM_HI = 3;
    localparam int B_EDGE   = 6;
    localparam int F_OVF    = 0;
    localparam int F_CAP    = 5;
    localparam int M_SRC    = 7;
    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // counter limits
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] TOP_8B   = 16'h00FF;
    localparam logic [15:0] TOP_9B   = 16'h01FF;
    localparam logic [15:0] TOP_10B  = 16'h03FF;
    // prescaler masks for divide by 1, 8, 64, 256, 1024
    localparam logic [9:0] PRE_1    = 10'h000;
    localparam logic [9:0] PRE_8    = 10'h007;
    localparam logic [9:0] PRE_64   = 10'h03F;
    localparam logic [9:0] PRE_256  = 10'h0FF;
    localparam logic [9:0] PRE_1024 = 10'h3FF;
    // host register offsets (haddr[3:0])
    localparam logic [3:0] H_CMD    = 4'h0;
    localparam logic [3:0] H_STATUS = 4'h4;
    localparam logic [3:0] H_ACK    = 4'h8;
    // host field positions
    localparam int C_DATA_LO = 0;
    localparam int C_ADDR_LO = 8;
    localparam int C_WRITE   = 16;
    localparam int C_READ    = 17;
    localparam int S_BUSY    = 8;
    localparam int S_OVF_IRQ = 9;
    localparam int S_CAP_IRQ = 10;
    localparam int K_OVF     = 0;
    localparam int K_CAP     = 1;
endpackage : tcp_pkg

// ### include/tcp_if.sv
// Purpose: byte-wide register port between timer and its controller
// Assumes: one clock, strobes last one cycle
// Notes:   read data stands from the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
interface tcp_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       ovf_irq;
    logic       cap_irq;
    logic       ovf_ack;
    logic       cap_ack;
    modport dev (input addr, wdata, wr, rd, ovf_ack, cap_ack,
                 output rdata, ovf_irq, cap_irq);
    modport cpu (output addr, wdata, wr, rd, ovf_ack, cap_ack,
                 input rdata, ovf_irq, cap_irq);
endinterface : tcp_if
`default_nettype wire

// ### hw/tcp_edge.sv
// Purpose: two-stage synchroniser with rise and fall pulses
// Assumes: input may be asynchronous
// Notes:   pulses last one clock
`timescale 1ns/1ps
`default_nettype none
module tcp_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // level in, pulses out
    input  wire logic d_in,
    output logic      rise,
    output logic      fall
);
    logic s1_r, s2_r, prev_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            s1_r   <= d_in;
            s2_r   <= s1_r;
            prev_r <= s2_r;
        end
    end

    // edges seen only past the second stage
    assign rise = s2_r & ~prev_r;
    assign fall = ~s2_r & prev_r;
endmodule : tcp_edge
`default_nettype wire

// ### hw/tcp_timer.sv
// Purpose: 16-bit up/down timer with input capture, byte register port
// Assumes: strobes are one cycle; inputs synchronous except the pins
// Notes:   noise canceler and output compare pins not included
`timescale 1ns/1ps
`default_nettype none
module tcp_timer (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // register port
    tcp_if.dev        bus,
    // event pins
    input  wire logic capture_input_pin,
    input  wire logic comparator_output,
    input  wire logic ext_clock_pin,
    // sequence position
    output logic      at_top,
    output logic      at_bottom
);
    logic [7:0]  ctrl_a_r, ctrl_b_r, temp_r, flags_r, mask_r, rdata_r;
    logic [7:0]  flags_nxt, temp_nxt;
    logic [15:0] cnt_r, cnt_nxt, cap_r, cap_nxt, cmpa_r;
    logic [9:0]  pre_r;
    logic        down_r, down_nxt, ovf_set;
    logic        ovf_irq_r, cap_irq_r, at_top_r, at_bottom_r;

    function automatic logic [15:0] top_of(input logic [3:0] m,
                                           input logic [15:0] a,
                                           input logic [15:0] c);
        case (m)
            4'd1, 4'd5:                top_of = tcp_pkg::TOP_8B;
            4'd2, 4'd6:                top_of = tcp_pkg::TOP_9B;
            4'd3, 4'd7:                top_of = tcp_pkg::TOP_10B;
            4'd4, 4'd9, 4'd11, 4'd15:  top_of = a;
            4'd8, 4'd10, 4'd12, 4'd14: top_of = c;
            default:                   top_of = tcp_pkg::CNT_MAX;
        endcase
    endfunction : top_of

    function automatic logic capture_is_top(input logic [3:0] m);
        capture_is_top = (m == 4'd8) || (m == 4'd10) || (m == 4'd12)
                      || (m == 4'd14);
    endfunction : capture_is_top

    wire [3:0] wgm = {ctrl_b_r[tcp_pkg::B_WGM_HI +: 2],
                      ctrl_a_r[tcp_pkg::A_WGM_LO +: 2]};
    wire [2:0] cs  = ctrl_b_r[tcp_pkg::B_CS_LO +: 3];
    wire [15:0] top = top_of(wgm, cmpa_r, cap_r);
    wire dual = (wgm >= 4'd1 && wgm <= 4'd3) || (wgm >= 4'd8 && wgm <= 4'd11);
    wire ctc  = (wgm == 4'd4) || (wgm == 4'd12);
    wire icr_top = capture_is_top(wgm);

    // decoded strobes
    wire wr_ctrl_a  = bus.wr && bus.addr == tcp_pkg::A_CTRL_A;
    wire wr_ctrl_b  = bus.wr && bus.addr == tcp_pkg::A_CTRL_B;
    wire wr_cnt_lo  = bus.wr && bus.addr == tcp_pkg::A_CNT_LO;
    wire wr_cap_lo  = bus.wr && bus.addr == tcp_pkg::A_CAP_LO;
    wire wr_cmpa_lo = bus.wr && bus.addr == tcp_pkg::A_CMPA_LO;
    wire wr_flags   = bus.wr && bus.addr == tcp_pkg::A_FLAGS;
    wire wr_mask    = bus.wr && bus.addr == tcp_pkg::A_MASK;
    wire wr_high    = bus.wr && (bus.addr == tcp_pkg::A_CNT_HI
                   || bus.addr == tcp_pkg::A_CAP_HI
                   || bus.addr == tcp_pkg::A_CMPA_HI);
    wire rd_cnt_lo  = bus.rd && bus.addr == tcp_pkg::A_CNT_LO;
    wire rd_cap_lo  = bus.rd && bus.addr == tcp_pkg::A_CAP_LO;

    // clock select, prescaler taps or external pin
    wire ext_rise, ext_fall;
    tcp_edge u_ext (
        .clk  (clk),
        .srst (srst),
        .d_in (ext_clock_pin),
        .rise (ext_rise),
        .fall (ext_fall)
    );
    wire [9:0] pre_mask = (cs == 3'd1) ? tcp_pkg::PRE_1
                        : (cs == 3'd2) ? tcp_pkg::PRE_8
                        : (cs == 3'd3) ? tcp_pkg::PRE_64
                        : (cs == 3'd4) ? tcp_pkg::PRE_256
                        : tcp_pkg::PRE_1024;
    // select zero gives no tick at all
    wire tick = (cs == 3'd0) ? 1'b0
              : (cs == 3'd6) ? ext_fall
              : (cs == 3'd7) ? ext_rise
              : ((pre_r & pre_mask) == pre_mask);

    // source chosen ahead of the synchroniser
    // switching source can fake an edge; software clears the flag after
    wire cap_src = mask_r[tcp_pkg::M_SRC] ? comparator_output
                                          : capture_input_pin;
    wire cap_rise, cap_fall;
    tcp_edge u_cap (
        .clk  (clk),
        .srst (srst),
        .d_in (cap_src),
        .rise (cap_rise),
        .fall (cap_fall)
    );
    // edge select; unit idle when capture defines top
    wire cap_evt = !icr_top
                && (ctrl_b_r[tcp_pkg::B_EDGE] ? cap_rise : cap_fall);

    always_comb begin
        cnt_nxt  = cnt_r;
        down_nxt = down_r;
        ovf_set  = 1'b0;
        // full word from temp and written byte
        if (wr_cnt_lo) begin
            cnt_nxt = {temp_r, bus.wdata};
        end else if (tick) begin
            if (dual) begin
                if (!down_r) begin
                    if (cnt_r >= top) begin
                        down_nxt = 1'b1;
                        cnt_nxt  = cnt_r - 16'h0001;
                    end else begin
                        cnt_nxt  = cnt_r + 16'h0001;
                    end
                end else if (cnt_r == 16'h0000) begin
                    down_nxt = 1'b0;
                    cnt_nxt  = 16'h0001;
                    ovf_set  = 1'b1;
                end else begin
                    cnt_nxt  = cnt_r - 16'h0001;
                end
            end else begin
                // clear-on-match flags at max, others at top
                down_nxt = 1'b0;
                ovf_set  = ctc ? (cnt_r == tcp_pkg::CNT_MAX) : (cnt_r == top);
                cnt_nxt  = (cnt_r == top) ? 16'h0000 : cnt_r + 16'h0001;
            end
        end
    end

    // capture copies count in the flag's cycle
    // capture writable only while it defines top
    assign cap_nxt = cap_evt ? cnt_r
                   : (wr_cap_lo && icr_top) ? {temp_r, bus.wdata}
                   : cap_r;

    // flag set wins over ack or write-one clear
    wire [7:0] fl_clr = (wr_flags ? bus.wdata : 8'h00)
                      | (8'(bus.ovf_ack) << tcp_pkg::F_OVF)
                      | (8'(bus.cap_ack) << tcp_pkg::F_CAP);
    wire [7:0] fl_set = (8'(ovf_set) << tcp_pkg::F_OVF)
                      | (8'(cap_evt) << tcp_pkg::F_CAP);
    assign flags_nxt = fl_set | (flags_r & ~fl_clr);

    // one temp register for every word
    // count and capture lower reads latch the upper byte
    assign temp_nxt = wr_high   ? bus.wdata
                    : rd_cnt_lo ? cnt_r[15:8]
                    : rd_cap_lo ? cap_r[15:8]
                    : temp_r;

    // upper count and capture read back temp
    wire [7:0] rd_mux =
          (bus.addr == tcp_pkg::A_CTRL_A)  ? ctrl_a_r
        : (bus.addr == tcp_pkg::A_CTRL_B)  ? ctrl_b_r
        : (bus.addr == tcp_pkg::A_CNT_LO)  ? cnt_r[7:0]
        : (bus.addr == tcp_pkg::A_CNT_HI)  ? temp_r
        : (bus.addr == tcp_pkg::A_CAP_LO)  ? cap_r[7:0]
        : (bus.addr == tcp_pkg::A_CAP_HI)  ? temp_r
        : (bus.addr == tcp_pkg::A_CMPA_LO) ? cmpa_r[7:0]
        : (bus.addr == tcp_pkg::A_CMPA_HI) ? cmpa_r[15:8]
        : (bus.addr == tcp_pkg::A_FLAGS)   ? flags_r
        : (bus.addr == tcp_pkg::A_MASK)    ? mask_r
        : 8'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_a_r <= tcp_pkg::RST_BYTE;
            ctrl_b_r <= tcp_pkg::RST_BYTE;
            temp_r   <= tcp_pkg::RST_BYTE;
            flags_r  <= tcp_pkg::RST_BYTE;
            mask_r   <= tcp_pkg::RST_BYTE;
            rdata_r  <= tcp_pkg::RST_BYTE;
            cnt_r    <= tcp_pkg::RST_WORD;
            cap_r    <= tcp_pkg::RST_WORD;
            cmpa_r   <= tcp_pkg::RST_WORD;
            pre_r    <= 10'h000;
            down_r   <= 1'b0;
        end else begin
            if (wr_ctrl_a) ctrl_a_r <= bus.wdata;
            if (wr_ctrl_b) ctrl_b_r <= bus.wdata;
            if (wr_mask)   mask_r   <= bus.wdata;
            if (wr_cmpa_lo) cmpa_r  <= {temp_r, bus.wdata};
            if (bus.rd)    rdata_r  <= rd_mux;
            temp_r  <= temp_nxt;
            flags_r <= flags_nxt;
            cnt_r   <= cnt_nxt;
            down_r  <= down_nxt;
            cap_r   <= cap_nxt;
            pre_r   <= (cs == 3'd0) ? 10'h000 : pre_r + 10'h001;
        end
    end

    // top and bottom from next count
    always_ff @(posedge clk) begin
        if (srst) begin
            at_top_r    <= 1'b0;
            at_bottom_r <= 1'b0;
            ovf_irq_r   <= 1'b0;
            cap_irq_r   <= 1'b0;
        end else begin
            at_top_r    <= (cnt_nxt == top);
            at_bottom_r <= (cnt_nxt == 16'h0000);
            ovf_irq_r   <= flags_nxt[tcp_pkg::F_OVF]
                         & mask_r[tcp_pkg::F_OVF];
            cap_irq_r   <= flags_nxt[tcp_pkg::F_CAP]
                         & mask_r[tcp_pkg::F_CAP];
        end
    end

    assign at_top      = at_top_r;
    assign at_bottom   = at_bottom_r;
    assign bus.rdata   = rdata_r;
    assign bus.ovf_irq = ovf_irq_r;
    assign bus.cap_irq = cap_irq_r;
endmodule : tcp_timer
`default_nettype wire

// ### hw/tcp_host.sv
// Purpose: AHB-Lite controller driving the timer's byte register port
// Assumes: single word transfers, zero wait states
// Notes:   a new command while a read is pending is dropped
`timescale 1ns/1ps
`default_nettype none
module tcp_host (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // timer port
    tcp_if.cpu               bus
);
    logic        dp_wr_r, busy_r, pend_r, wr_r, rd_r, oack_r, cack_r;
    logic [3:0]  dp_addr_r, addr_r;
    logic [7:0]  wdata_r, last_r;
    logic [31:0] hrdata_r;

    wire ap = hsel && htrans[1] && hready;
    wire cmd_wr = dp_wr_r && dp_addr_r == tcp_pkg::H_CMD && !busy_r;
    wire ack_wr = dp_wr_r && dp_addr_r == tcp_pkg::H_ACK;
    wire do_wr = cmd_wr && hwdata[tcp_pkg::C_WRITE];
    wire do_rd = cmd_wr && hwdata[tcp_pkg::C_READ] && !do_wr;
    wire [31:0] status = {21'h0, bus.cap_irq, bus.ovf_irq, busy_r, last_r};
    wire [31:0] rd_mux = (haddr[3:0] == tcp_pkg::H_STATUS) ? status
                       : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 4'h0;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            dp_wr_r   <= ap && hwrite;
            if (ap) dp_addr_r <= haddr[3:0];
            if (ap && !hwrite) hrdata_r <= rd_mux;
        end
    end

    // read data stands the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            oack_r  <= 1'b0;
            cack_r  <= 1'b0;
            pend_r  <= 1'b0;
            busy_r  <= 1'b0;
            addr_r  <= 4'h0;
            wdata_r <= 8'h00;
            last_r  <= 8'h00;
        end else begin
            wr_r   <= do_wr;
            rd_r   <= do_rd;
            oack_r <= ack_wr && hwdata[tcp_pkg::K_OVF];
            cack_r <= ack_wr && hwdata[tcp_pkg::K_CAP];
            pend_r <= rd_r;
            if (cmd_wr) begin
                addr_r  <= hwdata[tcp_pkg::C_ADDR_LO +: 4];
                wdata_r <= hwdata[tcp_pkg::C_DATA_LO +: 8];
            end
            if (pend_r) last_r <= bus.rdata;
            if (do_rd) busy_r <= 1'b1;
            else if (pend_r) busy_r <= 1'b0;
        end
    end

    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = hrdata_r;
    assign bus.addr    = addr_r;
    assign bus.wdata   = wdata_r;
    assign bus.wr      = wr_r;
    assign bus.rd      = rd_r;
    assign bus.ovf_ack = oack_r;
    assign bus.cap_ack = cack_r;
endmodule : tcp_host
`default_nettype wire

// ### testbench/tcp_props.sv
// Purpose: port checks on the timer register link
// Assumes: one clock, srst synchronous active high
// Notes:   pin history stands in for unseen capture events
`timescale 1ns/1ps
`default_nettype none
module tcp_props (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // register link
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    input  wire logic       ovf_irq,
    input  wire logic       cap_irq,
    input  wire logic       ovf_ack,
    input  wire logic       cap_ack,
    // event pins
    input  wire logic       capture_input_pin,
    input  wire logic       comparator_output
);
    logic [7:0] ctrl_a_r;
    logic [7:0] mask_r;
    logic [7:0] pin_hist_r;
    logic       wr_ctrl_a;
    logic       wr_mask;
    logic       pins_still;
    assign wr_ctrl_a = wr && (addr == tcp_pkg::A_CTRL_A);
    assign wr_mask = wr && (addr == tcp_pkg::A_MASK);
    // an edge needs three edges to reach the flag, so look back four
    assign pins_still = (pin_hist_r[7:4] == {4{capture_input_pin}})
                     && (pin_hist_r[3:0] == {4{comparator_output}});
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_a_r   <= 8'h00;
            mask_r     <= 8'h00;
            pin_hist_r <= 8'h00;
        end else begin
            if (wr_ctrl_a) ctrl_a_r <= wdata;
            if (wr_mask) mask_r <= wdata;
            pin_hist_r <= {pin_hist_r[6:4], capture_input_pin,
                           pin_hist_r[2:0], comparator_output};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_reset_quiet: assert property (
        $fell(srst) |-> rdata == 8'h00 && !ovf_irq && !cap_irq)
        else $error("link not quiet after reset");
    a_rdata_holds: assert property (
        !rd |=> $stable(rdata))
        else $error("read byte moved without a read");
    a_unmapped_zero: assert property (
        rd && addr > tcp_pkg::A_MASK |=> rdata == 8'h00)
        else $error("unmapped location read nonzero");
    a_mode_readback: assert property (
        rd && addr == tcp_pkg::A_CTRL_A |=> rdata[1:0] == ctrl_a_r[1:0])
        else $error("mode bits read back wrong");
    a_cap_masked: assert property (
        !mask_r[tcp_pkg::F_CAP] && !$past(mask_r[tcp_pkg::F_CAP])
        |-> !cap_irq)
        else $error("capture request while masked");
    a_ovf_masked: assert property (
        !mask_r[tcp_pkg::F_OVF] && !$past(mask_r[tcp_pkg::F_OVF])
        |-> !ovf_irq)
        else $error("overflow request while masked");
    a_cap_ack_clear: assert property (
        cap_ack && pins_still |=> !cap_irq)
        else $error("capture request survived its ack");
    a_rd_spacing: assert property (
        rd |=> (!rd && !wr) [*2])
        else $error("strobe too soon after a read");
endmodule : tcp_props
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: end-to-end bench for timer and host over the byte link
// Assumes: host answers with zero waits, one clock
// Notes:   timer kept stopped between checks so counts stay known
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        srst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        cap_pin;
    logic        cmp_out;
    logic        ext_pin;
    logic        at_top;
    logic        at_bottom;
    logic [31:0] r;
    logic [15:0] w;
    logic [7:0]  b;
    int          n_mismatch;
    int          compares;
    tcp_if bus_if ();
    tcp_host u_tcp_host (.clk(clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .bus(bus_if));
    tcp_timer u_tcp_timer (.clk(clk), .srst(srst), .bus(bus_if),
        .capture_input_pin(cap_pin), .comparator_output(cmp_out),
        .ext_clock_pin(ext_pin), .at_top(at_top), .at_bottom(at_bottom));
    tcp_props u_tcp_props (.clk(clk), .srst(srst), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
        .rdata(bus_if.rdata), .ovf_irq(bus_if.ovf_irq),
        .cap_irq(bus_if.cap_irq), .ovf_ack(bus_if.ovf_ack),
        .cap_ack(bus_if.cap_ack), .capture_input_pin(cap_pin),
        .comparator_output(cmp_out));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic ahb(input logic [31:0] a, input logic wr_en,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr_en;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : ahb
    task automatic tmr_wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        ahb(32'h0000_0000, 1'b1,
            (32'h1 << tcp_pkg::C_WRITE) | {20'h0, a, d}, q);
    endtask : tmr_wr
    task automatic tmr_rd(input logic [3:0] a, output logic [7:0] d);
        logic [31:0] st;
        int          k;
        ahb(32'h0000_0000, 1'b1,
            (32'h1 << tcp_pkg::C_READ) | {20'h0, a, 8'h00}, st);
        st = 32'hFFFF_FFFF;
        k = 0;
        // busy must drop before the latched byte is trusted
        while (st[tcp_pkg::S_BUSY] !== 1'b0 && k < 20) begin
            ahb(32'h0000_0004, 1'b0, 32'h0000_0000, st);
            k++;
        end
        // a read that never finishes counts against the run
        if (st[tcp_pkg::S_BUSY] !== 1'b0) n_mismatch++;
        d = st[7:0];
    endtask : tmr_rd
    task automatic word_wr(input logic [3:0] a, input logic [15:0] v);
        tmr_wr(a, v[15:8]);
        tmr_wr(a - 4'h1, v[7:0]);
    endtask : word_wr
    task automatic word_rd(input logic [3:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        tmr_rd(a, lo);
        tmr_rd(a + 4'h1, hi);
        v = {hi, lo};
    endtask : word_rd
    task automatic s_reset;
        ahb(32'h0000_0004, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        word_rd(tcp_pkg::A_CNT_LO, w);
        chk({16'h0, w}, 32'h0000_0000);
        word_rd(tcp_pkg::A_CAP_LO, w);
        chk({16'h0, w}, 32'h0000_0000);
    endtask : s_reset
    task automatic s_word;
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h00);
        word_wr(tcp_pkg::A_CNT_HI, 16'h1234);
        repeat (50) @(posedge clk);
        word_rd(tcp_pkg::A_CNT_LO, w);
        chk({16'h0, w}, 32'h0000_1234);
        tmr_wr(tcp_pkg::A_CMPA_HI, 8'hAB);
        tmr_wr(tcp_pkg::A_CNT_LO, 8'h56);
        word_rd(tcp_pkg::A_CNT_LO, w);
        chk({16'h0, w}, 32'h0000_AB56);
        tmr_rd(tcp_pkg::A_CNT_LO, b);
        tmr_rd(tcp_pkg::A_CAP_HI, b);
        chk({24'h0, b}, 32'h0000_00AB);
    endtask : s_word
    task automatic s_slope(input logic [7:0] mode_a, input logic [15:0] start,
                           input int gap);
        int k;
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h00);
        tmr_wr(tcp_pkg::A_CTRL_A, mode_a);
        tmr_wr(tcp_pkg::A_MASK, 8'h01);
        word_wr(tcp_pkg::A_CNT_HI, start);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h01);
        k = 0;
        while (at_top !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (at_bottom !== 1'b1 && k < 600);
        chk(32'(k), 32'(gap));
        ahb(32'h0000_0004, 1'b0, 32'h0000_0000, r);
        chk({31'h0, r[tcp_pkg::S_OVF_IRQ]}, 32'h0000_0001);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h00);
        ahb(32'h0000_0008, 1'b1, 32'h0000_0001, r);
        ahb(32'h0000_0004, 1'b0, 32'h0000_0000, r);
        chk({31'h0, r[tcp_pkg::S_OVF_IRQ]}, 32'h0000_0000);
    endtask : s_slope
    task automatic s_capture;
        logic [15:0] v;
        int          s;
        tmr_wr(tcp_pkg::A_CTRL_A, 8'h00);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h40);
        for (s = 0; s < 2; s++) begin
            v = s ? 16'h5A3D : 16'h5A3C;
            tmr_wr(tcp_pkg::A_MASK, s ? 8'hA0 : 8'h20);
            word_wr(tcp_pkg::A_CNT_HI, v);
            if (s) cmp_out <= 1'b1;
            else cap_pin <= 1'b1;
            repeat (8) @(posedge clk);
            chk({31'h0, bus_if.cap_irq}, 32'h0000_0001);
            word_rd(tcp_pkg::A_CAP_LO, w);
            chk({16'h0, w}, {16'h0, v});
            if (s) tmr_wr(tcp_pkg::A_FLAGS, 8'h20);
            else ahb(32'h0000_0008, 1'b1, 32'h0000_0002, r);
            ahb(32'h0000_0004, 1'b0, 32'h0000_0000, r);
            chk({31'h0, r[tcp_pkg::S_CAP_IRQ]}, 32'h0000_0000);
            // falling edge must leave the capture alone
            word_wr(tcp_pkg::A_CNT_HI, 16'h0001);
            cap_pin <= 1'b0;
            cmp_out <= 1'b0;
            repeat (8) @(posedge clk);
            chk({31'h0, bus_if.cap_irq}, 32'h0000_0000);
            word_rd(tcp_pkg::A_CAP_LO, w);
            chk({16'h0, w}, {16'h0, v});
        end
    endtask : s_capture
    task automatic s_cap_write;
        word_wr(tcp_pkg::A_CAP_HI, 16'h1122);
        word_rd(tcp_pkg::A_CAP_LO, w);
        chk({16'h0, w}, 32'h0000_5A3D);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h18);
        word_wr(tcp_pkg::A_CAP_HI, 16'h1122);
        word_rd(tcp_pkg::A_CAP_LO, w);
        chk({16'h0, w}, 32'h0000_1122);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h00);
    endtask : s_cap_write
    task automatic s_unmapped;
        ahb(32'h0000_000C, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        tmr_rd(4'hF, b);
        chk({24'h0, b}, 32'h0000_0000);
        tmr_wr(tcp_pkg::A_CTRL_A, 8'h03);
        tmr_rd(tcp_pkg::A_CTRL_A, b);
        chk({30'h0, b[1:0]}, 32'h0000_0003);
    endtask : s_unmapped
    task automatic s_ext;
        int n;
        tmr_wr(tcp_pkg::A_CTRL_A, 8'h00);
        word_wr(tcp_pkg::A_CNT_HI, 16'h0000);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h02);
        // divide by 8: ticks 8, 16 .. 80 cycles after the write lands
        repeat (80) @(posedge clk);
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h07);
        word_rd(tcp_pkg::A_CNT_LO, w);
        chk({16'h0, w}, 32'h0000_000A);
        // five rising edges, then five falling edges
        for (n = 0; n < 20; n++) begin
            if (n == 10) tmr_wr(tcp_pkg::A_CTRL_B, 8'h06);
            ext_pin <= ~ext_pin;
            repeat (4) @(posedge clk);
        end
        tmr_wr(tcp_pkg::A_CTRL_B, 8'h00);
        word_rd(tcp_pkg::A_CNT_LO, w);
        chk({16'h0, w}, 32'h0000_0014);
    endtask : s_ext
    initial begin
        srst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        cap_pin = 1'b0;
        cmp_out = 1'b0;
        ext_pin = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        s_reset;
        s_word;
        s_slope(8'h00, 16'hFFF0, 1);
        s_slope(8'h01, 16'h00F0, 255);
        s_capture;
        s_cap_write;
        s_unmapped;
        s_ext;
        // second reset mid-run must clear what the tests left behind
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        s_reset;
        wrap_up;
    end
    initial begin
        #200000;
        n_mismatch++;
        wrap_up;
    end
endmodule : tb_top
`default_nettype wire
